// File: dv/serial_link_startup_sequencer_bench.sv
`timescale 1ns/1ps
module serial_link_startup_sequencer_bench;
  localparam int GUARD = 40;
  localparam int LOCK  = 4;
  localparam int DW    = 24;

  logic          sys_clk     = 1'b0;
  logic          reset       = 1'b1;
  logic          clk_en      = 1'b1;
  logic          cc_wr_valid = 1'b0;
  logic [1:0]    cc_wr_sel   = 2'h0;
  logic [7:0]    cc_wr_data  = 8'h00;
  logic          ser_cfg_en   = 1'b1;
  logic          ser_video_en = 1'b0;
  logic          ser_width    = 1'b0;
  logic          ser_detect   = 1'b0;
  logic          cfg_link_detect, video_link_detect, remote_bus_width, remote_error_detect;
  logic          cc_ready, cc_ack, rate_range_select, bus_width_select, error_detect_select;
  logic          cfg_lock, video_lock, video_valid;
  logic [7:0]    misc_config;
  logic [DW-1:0] video_data_in, video_data, exp_word;
  int            error_cnt   = 0;
  int            check_count = 0;
  int            n;

  always #2.5 sys_clk = ~sys_clk;

  serializer_model #(.DW(DW)) partner (
    .sys_clk(sys_clk), .reset(reset), .config_link_enable(ser_cfg_en), .serialization_enable(ser_video_en),
    .bus_width_select(ser_width), .error_detect_select(ser_detect),
    .cfg_link_detect(cfg_link_detect), .video_link_detect(video_link_detect),
    .remote_bus_width(remote_bus_width), .remote_error_detect(remote_error_detect), .video_data_in(video_data_in));

  link_startup #(.GUARD_CYCLES(GUARD), .LOCK_CYCLES(LOCK), .DATA_WIDTH(DW)) dut (
    .sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .cfg_link_detect(cfg_link_detect),
    .video_link_detect(video_link_detect), .remote_bus_width(remote_bus_width),
    .remote_error_detect(remote_error_detect), .video_data_in(video_data_in), .cc_wr_valid(cc_wr_valid),
    .cc_wr_sel(cc_wr_sel), .cc_wr_data(cc_wr_data), .cc_ready(cc_ready), .cc_ack(cc_ack),
    .rate_range_select(rate_range_select), .bus_width_select(bus_width_select),
    .error_detect_select(error_detect_select), .misc_config(misc_config), .cfg_lock(cfg_lock),
    .video_lock(video_lock), .video_valid(video_valid), .video_data(video_data));

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    reset <= 1'b1;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    #1;
    check("rate", rate_range_select, link_startup_pkg::RATE_DEFAULT);
    check("width", bus_width_select, link_startup_pkg::WIDTH_DEFAULT);
    check("detect", error_detect_select, link_startup_pkg::DETECT_DEFAULT);
    check("misc", misc_config, link_startup_pkg::MISC_DEFAULT);
    check("ready", cc_ready, 1'b0);
  endtask

  task automatic wr(input logic [1:0] sel, input logic [7:0] data, input logic ack);
    @(posedge sys_clk);
    cc_wr_valid <= 1'b1;
    cc_wr_sel   <= sel;
    cc_wr_data  <= data;
    @(posedge sys_clk);
    cc_wr_valid <= 1'b0;
    #1;
    check("ack", cc_ack, ack);
  endtask

  // which: 0 config lock up, 1 video lock up, 2 video lock down
  task automatic wait_sig(input int which, input int lim, output int cnt);
    logic hit;
    cnt = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge sys_clk);
      #1;
      cnt++;
      hit = (which == 0) ? (cfg_lock === 1'b1) : (which == 1) ? (video_lock === 1'b1) : (video_lock === 1'b0);
      if (!hit && cnt >= lim) begin
        check("wait hit", hit, 1'b1);
        complete_run();
      end
    end
  endtask

  // ***************************************************************
  // sequence
  // ***************************************************************
  initial begin
    do_reset();
    wr(link_startup_pkg::SEL_MISC, 8'hff, 1'b0);
    check("misc", misc_config, 8'h00);
    wait_sig(0, GUARD + LOCK + 8, n);
    check("guard", n >= GUARD, 1'b1);
    check("ready", cc_ready, 1'b1);
    wr(link_startup_pkg::SEL_RATE, 8'h01, 1'b1);
    check("rate", rate_range_select, 1'b1);
    @(posedge sys_clk);
    #1;
    check("lock", cfg_lock, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr((i == 0) ? link_startup_pkg::SEL_WIDTH : link_startup_pkg::SEL_DETECT, 8'h01, 1'b1);
      check("fmt", (i == 0) ? bus_width_select : error_detect_select, 1'b1);
      @(posedge sys_clk);
      #1;
      check("drop", cfg_lock, 1'b0);
      check("ready", cc_ready, 1'b0);
      wr(link_startup_pkg::SEL_MISC, 8'h33, 1'b0);
      @(posedge sys_clk);
      ser_width  <= ser_width | (i == 0);
      ser_detect <= ser_detect | (i == 1);
      wait_sig(0, LOCK + 8, n);
    end
    check("misc", misc_config, 8'h00);
    wr(link_startup_pkg::SEL_MISC, 8'h5a, 1'b1);
    check("misc", misc_config, 8'h5a);
    @(posedge sys_clk);
    ser_video_en <= 1'b1;
    wait_sig(1, LOCK + 8, n);
    check("cfg", cfg_lock, 1'b0);
    check("ready", cc_ready, 1'b1);
    @(negedge sys_clk);
    exp_word = video_data_in;
    @(posedge sys_clk);
    #1;
    check("data", video_data, exp_word);
    check("valid", video_valid, 1'b1);
    // clock enable low must freeze the capture although the link word keeps moving
    @(negedge sys_clk);
    exp_word = video_data_in;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check("frozen data", video_data, exp_word);
    check("frozen lock", video_lock, 1'b1);
    @(posedge sys_clk);
    clk_en       <= 1'b1;
    ser_video_en <= 1'b0;
    wait_sig(2, 4, n);
    check("ready", cc_ready, 1'b0);
    @(posedge sys_clk);
    ser_width    <= 1'b0;
    ser_detect   <= 1'b0;
    ser_cfg_en   <= 1'b0;
    ser_video_en <= 1'b1;
    do_reset();
    wait_sig(1, GUARD + LOCK + 10, n);
    check("guard", n >= GUARD, 1'b1);
    wr(link_startup_pkg::SEL_WIDTH, 8'h01, 1'b1);
    @(posedge sys_clk);
    #1;
    check("drop", video_lock, 1'b0);
    @(posedge sys_clk);
    ser_width <= 1'b1;
    wait_sig(1, LOCK + 8, n);
    complete_run();
  end
endmodule

// File: dv/serializer_model.sv
`timescale 1ns/1ps
module serializer_model #(
  parameter int DW = 24
) (
  // clock and reset
  input  wire logic          sys_clk,
  input  wire logic          reset,
  // commands from the controller
  input  wire logic          config_link_enable,
  input  wire logic          serialization_enable,
  input  wire logic          bus_width_select,
  input  wire logic          error_detect_select,
  // link towards the deserializer
  output logic               cfg_link_detect,
  output logic               video_link_detect,
  output logic               remote_bus_width,
  output logic               remote_error_detect,
  output logic [DW-1:0]      video_data_in
);
  logic          cfg_on_q;
  logic          video_on_q;
  logic          width_q;
  logic          detect_q;
  logic [DW-1:0] word_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cfg_on_q   <= 1'b0;
      video_on_q <= 1'b0;
      width_q    <= 1'b0;
      detect_q   <= 1'b0;
      word_q     <= '0;
    end else begin
      cfg_on_q   <= config_link_enable;
      video_on_q <= serialization_enable;
      width_q    <= bus_width_select;
      detect_q   <= error_detect_select;
      word_q     <= word_q + DW'(24'h0a5c37);
    end
  end

  assign cfg_link_detect     = cfg_on_q & ~video_on_q;
  assign video_link_detect   = video_on_q;
  assign remote_bus_width    = width_q;
  assign remote_error_detect = detect_q;
  // word moves every cycle so a stale sample never matches
  assign video_data_in       = word_q;
endmodule

// File: hw/cycle_timer.sv
`timescale 1ns/1ps
module cycle_timer #(
  parameter int CW = 19
) (
  // clock and reset
  input wire logic    sys_clk,
  input wire logic    reset,
  // control
  cycle_timer_if.timer tif
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire           at_limit = (cnt_q == tif.limit);

  // ***************************************************************
  // count up to limit on ce cycles while run, cleared on any ce cycle with run low
  // ***************************************************************
  assign cnt_d       = !tif.run ? '0 : (at_limit ? cnt_q : cnt_q + CW'(1));
  assign tif.expired = tif.run && at_limit;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (tif.ce) begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// File: hw/cycle_timer_if.sv
`timescale 1ns/1ps
interface cycle_timer_if #(parameter int CW = 19);
  logic          ce;
  logic          run;
  logic [CW-1:0] limit;
  logic          expired;

  modport ctrl  (output ce, output run, output limit, input expired);
  modport timer (input ce, input run, input limit, output expired);
endinterface

// File: hw/link_startup.sv
`timescale 1ns/1ps
module link_startup #(
  parameter int GUARD_CYCLES = link_startup_pkg::GUARD_CYCLES,
  parameter int LOCK_CYCLES  = link_startup_pkg::LOCK_ACQ_CYCLES,
  parameter int DATA_WIDTH   = 24
) (
  // clock, reset, enable
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // serial link indications
  input  wire logic                  cfg_link_detect,
  input  wire logic                  video_link_detect,
  input  wire logic                  remote_bus_width,
  input  wire logic                  remote_error_detect,
  input  wire logic [DATA_WIDTH-1:0] video_data_in,
  // control-channel write port
  input  wire logic                  cc_wr_valid,
  input  wire logic [1:0]            cc_wr_sel,
  input  wire logic [7:0]            cc_wr_data,
  output logic                       cc_ready,
  output logic                       cc_ack,
  // configuration state
  output logic                       rate_range_select,
  output logic                       bus_width_select,
  output logic                       error_detect_select,
  output logic [7:0]                 misc_config,
  // link status and data
  output logic                       cfg_lock,
  output logic                       video_lock,
  output logic                       video_valid,
  output logic [DATA_WIDTH-1:0]      video_data
);

  localparam int CW = $clog2(GUARD_CYCLES + 1);

  if (LOCK_CYCLES < 1 || GUARD_CYCLES < LOCK_CYCLES || DATA_WIDTH < 1) begin : g_bad_params
    $error("link_startup: unsupported parameter values");
  end

  // ***************************************************************
  // declarations
  // ***************************************************************
  link_startup_pkg::link_state_t state_q;
  link_startup_pkg::link_state_t state_d;
  logic                  rate_q;
  logic                  width_q;
  logic                  detect_q;
  logic [7:0]            misc_q;
  logic                  ack_q;
  logic                  vvalid_q;
  logic [DATA_WIDTH-1:0] vdata_q;

  cycle_timer_if #(.CW(CW)) tif ();

  cycle_timer #(.CW(CW)) u_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tif     (tif)
  );

  // ***************************************************************
  // decoding
  // ***************************************************************
  wire fmt_match  = (width_q == remote_bus_width) && (detect_q == remote_error_detect);
  wire in_guard   = (state_q == link_startup_pkg::ST_GUARD);
  wire in_cfg_acq = (state_q == link_startup_pkg::ST_CFG_ACQ);
  wire in_vid_acq = (state_q == link_startup_pkg::ST_VID_ACQ);
  wire wr_accept  = cc_wr_valid && cc_ready;
  wire wr_rate    = wr_accept && (cc_wr_sel == link_startup_pkg::SEL_RATE);
  wire wr_width   = wr_accept && (cc_wr_sel == link_startup_pkg::SEL_WIDTH);
  wire wr_detect  = wr_accept && (cc_wr_sel == link_startup_pkg::SEL_DETECT);
  wire wr_misc    = wr_accept && (cc_wr_sel == link_startup_pkg::SEL_MISC);

  assign tif.ce    = clk_en;
  assign tif.run   = in_guard || in_cfg_acq || in_vid_acq;
  assign tif.limit = in_guard ? CW'(GUARD_CYCLES) : CW'(LOCK_CYCLES);

  assign cfg_lock   = (state_q == link_startup_pkg::ST_CFG_LOCK);
  assign video_lock = (state_q == link_startup_pkg::ST_VID_LOCK);
  assign cc_ready   = !in_guard && (cfg_lock || video_lock);

  assign rate_range_select   = rate_q;
  assign bus_width_select    = width_q;
  assign error_detect_select = detect_q;
  assign misc_config         = misc_q;
  assign cc_ack              = ack_q;
  assign video_valid         = vvalid_q;
  assign video_data          = vdata_q;

  // ***************************************************************
  // link state machine
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      link_startup_pkg::ST_GUARD: begin
        if (tif.expired) begin
          state_d = link_startup_pkg::ST_SEARCH;
        end
      end
      link_startup_pkg::ST_SEARCH: begin
        if (video_link_detect && fmt_match) begin
          state_d = link_startup_pkg::ST_VID_ACQ;
        end else if (cfg_link_detect && fmt_match && !video_link_detect) begin
          state_d = link_startup_pkg::ST_CFG_ACQ;
        end
      end
      link_startup_pkg::ST_CFG_ACQ: begin
        if (video_link_detect || !cfg_link_detect || !fmt_match) begin
          state_d = link_startup_pkg::ST_SEARCH;
        end else if (tif.expired) begin
          state_d = link_startup_pkg::ST_CFG_LOCK;
        end
      end
      link_startup_pkg::ST_CFG_LOCK: begin
        if (video_link_detect && fmt_match) begin
          state_d = link_startup_pkg::ST_VID_ACQ;
        end else if (video_link_detect || !cfg_link_detect || !fmt_match) begin
          state_d = link_startup_pkg::ST_SEARCH;
        end
      end
      link_startup_pkg::ST_VID_ACQ: begin
        if (!video_link_detect || !fmt_match) begin
          state_d = link_startup_pkg::ST_SEARCH;
        end else if (tif.expired) begin
          state_d = link_startup_pkg::ST_VID_LOCK;
        end
      end
      link_startup_pkg::ST_VID_LOCK: begin
        if (!video_link_detect || !fmt_match) begin
          state_d = link_startup_pkg::ST_SEARCH;
        end
      end
      default: begin
        state_d = link_startup_pkg::ST_SEARCH;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= link_startup_pkg::ST_GUARD;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // ***************************************************************
  // configuration registers, applied at once on write
  // ***************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rate_q <= link_startup_pkg::RATE_DEFAULT;
      width_q  <= link_startup_pkg::WIDTH_DEFAULT;
      detect_q <= link_startup_pkg::DETECT_DEFAULT;
      misc_q <= link_startup_pkg::MISC_DEFAULT;
      ack_q  <= 1'b0;
    end else if (clk_en) begin
      if (wr_rate) rate_q <= cc_wr_data[0];
      if (wr_width)  width_q  <= cc_wr_data[0];
      if (wr_detect) detect_q <= cc_wr_data[0];
      if (wr_misc) misc_q <= cc_wr_data;
      ack_q <= wr_accept;
    end
  end

  // ***************************************************************
  // deserialized output
  // ***************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vvalid_q <= 1'b0;
      vdata_q  <= '0;
    end else if (clk_en) begin
      vvalid_q <= video_lock;
      if (video_lock) vdata_q <= video_data_in;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  logic [CW-1:0] since_rst_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      since_rst_q <= '0;
    end else if (clk_en && since_rst_q != CW'(GUARD_CYCLES)) begin
      since_rst_q <= since_rst_q + CW'(1);
    end
  end

  ready_needs_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cc_wr_valid && !cfg_lock && !video_lock && clk_en) |=> !cc_ack && $stable(misc_config))
    else $error("control channel write served without a locked link");

  guard_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
    cc_ready |-> (since_rst_q == CW'(GUARD_CYCLES)))
    else $error("control channel ready inside power-up guard");

  reset_defaults_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> (rate_q == link_startup_pkg::RATE_DEFAULT && width_q == link_startup_pkg::WIDTH_DEFAULT
                      && detect_q == link_startup_pkg::DETECT_DEFAULT && misc_q == link_startup_pkg::MISC_DEFAULT))
    else $error("configuration not at defaults after reset");

  cfg_lock_gain_a: assert property (@(posedge sys_clk) disable iff (reset)
    (in_cfg_acq && tif.expired && cfg_link_detect && fmt_match && !video_link_detect && clk_en) |=> cfg_lock)
    else $error("configuration link lock not taken");

  fmt_apply_a: assert property (@(posedge sys_clk) disable iff (reset)
    (wr_width && clk_en) |=> (width_q == $past(cc_wr_data[0])) && cc_ack)
    else $error("bus width write not applied at once");

  cfg_relock_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == link_startup_pkg::ST_SEARCH && cfg_link_detect && fmt_match && !video_link_detect && clk_en)
    |=> in_cfg_acq)
    else $error("configuration relock not started");

  video_out_a: assert property (@(posedge sys_clk) disable iff (reset)
    (video_lock && clk_en) |=> video_valid && (video_data == $past(video_data_in)))
    else $error("video data not produced while locked");

  auto_lock_a: assert property (@(posedge sys_clk) disable iff (reset)
    (state_q == link_startup_pkg::ST_SEARCH && video_link_detect && fmt_match && clk_en) |=> in_vid_acq)
    else $error("serial link lock not started automatically");

  mismatch_drop_a: assert property (@(posedge sys_clk) disable iff (reset)
    (video_lock && !fmt_match && clk_en) |=> !video_lock)
    else $error("video lock kept with mismatched format");

  video_override_a: assert property (@(posedge sys_clk) disable iff (reset)
    (cfg_lock && video_link_detect && fmt_match && clk_en) |=> in_vid_acq)
    else $error("video link did not override configuration link");

endmodule

// File: hw/link_startup_pkg.sv
package link_startup_pkg;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int SYS_CLK_MHZ      = 200;
  localparam int POWERUP_GUARD_MS = 2;
  localparam int GUARD_CYCLES     = POWERUP_GUARD_MS * SYS_CLK_MHZ * 1000;
  localparam int LOCK_ACQ_CYCLES  = 16;

  // ***************************************************************
  // control-channel write selects
  // ***************************************************************
  localparam logic [1:0] SEL_RATE   = 2'h0;
  localparam logic [1:0] SEL_WIDTH  = 2'h1;
  localparam logic [1:0] SEL_DETECT = 2'h2;
  localparam logic [1:0] SEL_MISC   = 2'h3;

  // ***************************************************************
  // values after reset
  // ***************************************************************
  localparam logic       RATE_DEFAULT   = 1'b0;
  localparam logic       WIDTH_DEFAULT  = 1'b0;
  localparam logic       DETECT_DEFAULT = 1'b0;
  localparam logic [7:0] MISC_DEFAULT   = 8'h00;

  // ***************************************************************
  // link states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_GUARD    = 3'h0,
    ST_SEARCH   = 3'h1,
    ST_CFG_ACQ  = 3'h2,
    ST_CFG_LOCK = 3'h3,
    ST_VID_ACQ  = 3'h4,
    ST_VID_LOCK = 3'h5
  } link_state_t;

endpackage
